// ---- rmcs_top.sv ----
// reset sequencer, mode latch, debug pin and clock source selection
// assumes clock is the self-clock, reset_n is the power-on reset, pins are async
`timescale 1ns/1ns

module rmcs_top
  import rmcs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        lvd_reset_req,
  input  wire logic        cop_reset_req,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  input  wire logic        debug_mode_pin_in,
  output logic             debug_mode_pin_out,
  output logic             debug_mode_pin_oe,
  input  wire logic [15:0] main_freq_khz,
  input  wire logic [15:0] ext_ref_freq_khz,
  output logic             sys_reset_n,
  output logic             active_bkgd_mode,
  output logic             fixed_freq_enable,
  output logic      [1:0]  main_clock_out_sel,
  output logic             osc_range,
  output logic             stop_self_clock_sel,
  output logic             rti_ext_ref_sel,
  output logic             debug_clk_local,
  output logic             crystal_out_pin_out,
  output logic             crystal_out_pin_oe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  rmcs_state_t      state;
  rmcs_state_t      next_state;
  logic [CNT_W-1:0] cnt;
  logic [3:0]       reset_cause_status;
  logic [7:0]       clockgen_control1;
  logic [7:0]       background_debug_ctrl;
  logic [2:0]       rpin_sync;
  logic [2:0]       dpin_sync;
  logic             rpin_level;
  logic             dpin_level;
  logic [3:0]       tick_div;
  logic             dbg_tick;
  logic             tx_busy;
  logic             tx_bit;
  logic [3:0]       tx_pos;
  logic             tx_drive;
  logic             tx_high;
  logic [CNT_W-1:0] oe_len;
  logic [CNT_W-1:0] gap_len;
  logic [4:0]       ticks_seen;
  logic             sample_now;
  logic             release_now;

  function automatic logic [CNT_W-1:0] rmcs_inc(input logic [CNT_W-1:0] v);
    rmcs_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction : rmcs_inc

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // three stages; the level moves only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rpin_sync <= 3'h7;
      dpin_sync <= 3'h7;
    end else begin
      rpin_sync <= {rpin_sync[1:0], reset_pin_in};
      dpin_sync <= {dpin_sync[1:0], debug_mode_pin_in};
    end
  end

  // filtered levels; pullups make high the idle value
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rpin_level <= 1'b1;
      dpin_level <= 1'b1;
    end else begin
      if (rpin_sync[2] == rpin_sync[1])
        rpin_level <= rpin_sync[2];
      if (dpin_sync[2] == dpin_sync[1])
        dpin_level <= dpin_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  assign sample_now  = (state == ST_WAIT) && (cnt == WAIT_CYC - 1'b1);
  assign release_now = (sample_now && rpin_level) || ((state == ST_HOLD) && rpin_level);

  // all counts run on the self-clock, so startup never needs another source [R17]
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (!rpin_level || lvd_reset_req || cop_reset_req)  // [R5]
          next_state = ST_DRIVE;
      end
      ST_DRIVE: begin
        if (cnt == DRIVE_CYC - 1'b1)  // [R1]
          next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (sample_now)  // [R2]
          next_state = rpin_level ? ST_RUN : ST_HOLD;
      end
      ST_HOLD: begin
        // someone outside still holds the pin low; wait for release
        if (rpin_level)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  // power-on reset starts a full drive and sample sequence
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_DRIVE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= (next_state != state) ? '0 : rmcs_inc(cnt);
    end
  end

  // pin driven low exactly while in the drive state [R1]
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reset_pin_oe  <= 1'b1;
      reset_pin_out <= 1'b0;
    end else begin
      reset_pin_oe  <= (next_state == ST_DRIVE);
      reset_pin_out <= 1'b0;
    end
  end

  // chip stays in reset until the sample has been taken [R23]
  always_ff @(posedge clock) begin
    if (!reset_n)
      sys_reset_n <= 1'b0;
    else
      sys_reset_n <= (next_state == ST_RUN);
  end

  // cause of the latest reset replaces the old one [R4]
  // a low sample after an internal reset means the pin was held outside [R3]
  always_ff @(posedge clock) begin
    if (!reset_n)
      reset_cause_status <= CAUSE_POR;
    else if (state == ST_RUN && next_state == ST_DRIVE)
      reset_cause_status <= (rpin_level ? 4'h0 : CAUSE_PIN)
                          | (cop_reset_req ? CAUSE_COP : 4'h0)
                          | (lvd_reset_req ? CAUSE_LVD : 4'h0);
    else if (sample_now && !rpin_level)
      reset_cause_status <= reset_cause_status | CAUSE_PIN;
  end

  // mode pin caught on the release edge: low means background mode [R8] [R9] [R23]
  always_ff @(posedge clock) begin
    if (!reset_n)
      active_bkgd_mode <= 1'b0;
    else if (release_now)
      active_bkgd_mode <= !dpin_level;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // controls return to defaults whenever the chip is in reset
  always_ff @(posedge clock) begin
    if (!reset_n || state != ST_RUN) begin
      clockgen_control1     <= C1_RESET;
      background_debug_ctrl <= DBG_RESET;
    end else if (reg_write) begin
      if (reg_addr == REG_CLOCKGEN_C1) begin
        // the fourth source code does not exist; keep the old choice [R16]
        clockgen_control1[7:2] <= reg_wdata[7:2];
        if (reg_wdata[1:0] != 2'h3)
          clockgen_control1[1:0] <= reg_wdata[1:0];
      end else if (reg_addr == REG_DBG_CTRL) begin
        background_debug_ctrl <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock selection outputs
  // ----------------------------------------------------------------
  // fixed clock is external reference only when the main clock is fast [R14] [R15]
  always_ff @(posedge clock) begin
    if (!reset_n)
      fixed_freq_enable <= 1'b0;
    else
      fixed_freq_enable <= {2'h0, main_freq_khz}
                           > ({2'h0, ext_ref_freq_khz} << FREF_RATIO_SH);
  end

  // copies of control bits, crystal output data gated by the oscillator bit, registered for clean outputs
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      main_clock_out_sel  <= SRC_CRYSTAL;
      osc_range           <= 1'b0;
      stop_self_clock_sel <= 1'b0;
      rti_ext_ref_sel     <= 1'b0;
      debug_clk_local     <= 1'b0;
      crystal_out_pin_oe  <= 1'b0;
      crystal_out_pin_out <= 1'b0;
    end else begin
      main_clock_out_sel  <= clockgen_control1[1:0];              // [R16]
      osc_range           <= clockgen_control1[C1_RANGE];         // [R21]
      stop_self_clock_sel <= clockgen_control1[C1_STOPSC];        // [R18]
      rti_ext_ref_sel     <= clockgen_control1[C1_RTIREF];        // [R20]
      debug_clk_local     <= background_debug_ctrl[DBG_LOCAL];    // [R19]
      crystal_out_pin_oe  <= clockgen_control1[C1_EXTOSC];        // [R22]
      crystal_out_pin_out <= clockgen_control1[C1_EXTOSC] & clockgen_control1[C1_XDATA];
    end
  end

  // ----------------------------------------------------------------
  // debug clock and bit transmitter
  // ----------------------------------------------------------------
  // bus clock ticks every cycle; local self-clock is a divided tick [R12] [R19]
  // divider restarts with each bit, so its first tick is a whole one [R11]
  always_ff @(posedge clock) begin
    if (!reset_n || !tx_busy || tick_div == LOCAL_DIV - 1'b1
        || !background_debug_ctrl[DBG_LOCAL])
      tick_div <= 4'h0;
    else
      tick_div <= tick_div + 1'b1;
  end
  assign dbg_tick = !background_debug_ctrl[DBG_LOCAL] || (tick_div == LOCAL_DIV - 1'b1);

  // one bit is 16 ticks: low, short speedup high, then released [R11] [R13]
  always_ff @(posedge clock) begin
    if (!reset_n || state != ST_RUN) begin
      tx_busy <= 1'b0;
      tx_bit  <= 1'b0;
      tx_pos  <= 4'h0;
    end else if (!tx_busy) begin
      tx_pos <= 4'h0;
      // no link traffic while the pin is a port bit
      if (reg_write && reg_addr == REG_DEBUG_TX && !background_debug_ctrl[DBG_PORT]) begin
        tx_busy <= 1'b1;
        tx_bit  <= reg_wdata[0];
      end
    end else if (dbg_tick) begin
      tx_pos <= tx_pos + 1'b1;
      if (tx_pos == BIT_TICKS)  // [R11]
        tx_busy <= 1'b0;
    end
  end

  assign tx_drive = tx_busy && (tx_pos < (tx_bit ? LOW_ONE : LOW_ZERO));
  assign tx_high  = tx_busy && (tx_pos == (tx_bit ? LOW_ONE : LOW_ZERO));

  // mode input in reset, debug pin or output-only port bit after [R6] [R7] [R10]
  always_ff @(posedge clock) begin
    if (!reset_n || next_state != ST_RUN) begin
      debug_mode_pin_oe  <= 1'b0;  // [R6]
      debug_mode_pin_out <= 1'b0;
    end else if (background_debug_ctrl[DBG_PORT]) begin
      debug_mode_pin_oe  <= 1'b1;  // [R10]
      debug_mode_pin_out <= background_debug_ctrl[DBG_PDATA];
    end else begin
      debug_mode_pin_oe  <= tx_drive || tx_high;  // [R7] [R13]
      debug_mode_pin_out <= tx_high;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // data stands one cycle after the read strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (!reset_n || !reg_read)
      reg_rdata <= 8'h00;
    else if (reg_addr == REG_RESET_CAUSE)
      reg_rdata <= {4'h0, reset_cause_status};
    else if (reg_addr == REG_CLOCKGEN_C1)
      reg_rdata <= clockgen_control1;
    else if (reg_addr == REG_DBG_CTRL)
      reg_rdata <= background_debug_ctrl;
    else if (reg_addr == REG_DEBUG_TX)
      reg_rdata <= {7'h00, tx_busy};
    else if (reg_addr == REG_SYS_STATUS)
      reg_rdata <= {3'h0, rpin_level, tx_busy, dpin_level, active_bkgd_mode,
                    fixed_freq_enable};
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // checks and their helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      oe_len     <= '0;
      gap_len    <= '0;
      ticks_seen <= 5'h00;
    end else begin
      oe_len     <= reset_pin_oe ? rmcs_inc(oe_len) : '0;
      gap_len    <= reset_pin_oe ? '0 : rmcs_inc(gap_len);
      ticks_seen <= !tx_busy ? 5'h00 : ticks_seen + 5'(dbg_tick);
    end
  end

  drive_length_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R1]
    $fell(reset_pin_oe) |-> oe_len == DRIVE_CYC)
    else $error("reset pin drive length wrong");

  sample_delay_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R2]
    ($past(state) == ST_WAIT && state != ST_WAIT) |-> gap_len == WAIT_CYC)
    else $error("reset pin sample delay wrong");

  reset_hold_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R23]
    (reset_pin_oe || state == ST_WAIT || state == ST_HOLD) |-> !sys_reset_n)
    else $error("internal reset released early");

  mode_latch_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R9]
    $rose(sys_reset_n) |-> active_bkgd_mode == !$past(dpin_level))
    else $error("mode not latched at release");

  mode_input_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R6]
    !sys_reset_n |-> !debug_mode_pin_oe)
    else $error("mode pin driven during reset");

  fixed_clock_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R14]
    ##1 fixed_freq_enable == ($past(main_freq_khz) > 4 * $past(ext_ref_freq_khz)))
    else $error("fixed frequency enable wrong");

  bit_length_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R11]
    ($fell(tx_busy) && sys_reset_n) |-> ticks_seen == 5'h10)
    else $error("debug bit not 16 ticks");

  speedup_pulse_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R13]
    ($rose(debug_mode_pin_out) && !$past(background_debug_ctrl[DBG_PORT]))
      |-> $past(debug_mode_pin_oe) ##1 (!debug_mode_pin_out || debug_mode_pin_oe))
    else $error("speedup pulse not after low drive");

  clock_source_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R16]
    main_clock_out_sel != 2'h3)
    else $error("illegal main clock source");

  port_output_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R10]
    (background_debug_ctrl[DBG_PORT] && next_state == ST_RUN) |=> debug_mode_pin_oe)
    else $error("port bit not driven");

  // a watchdog request shows in the cause bits from the first drive cycle
  cause_record_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R4]
    ($past(state) == ST_RUN && state == ST_DRIVE)
      |-> ((reset_cause_status & CAUSE_COP) != 4'h0) == $past(cop_reset_req))
    else $error("reset cause not recorded");

  // run may follow the wait state only on a high pin sample
  sample_high_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R3]
    ($past(state) == ST_WAIT && state == ST_RUN) |-> $past(rpin_level))
    else $error("run entered on low sample");

  // a bit opens with the line driven low one cycle after busy rises
  bit_start_a : assert property (@(posedge clock) disable iff (!reset_n)  // [R7]
    ($rose(tx_busy) && next_state == ST_RUN) |=> (debug_mode_pin_oe && !debug_mode_pin_out))
    else $error("debug bit did not start low");

endmodule : rmcs_top

// ---- rmcs_pkg.sv ----
// reset, mode select and clock select constants for the startup block
// assumes one 125 MHz clock standing in for the internal self-clock
//
// Notes on behaviour
// R1: any reset drives the reset pin low about 34 self-clock cycles, then releases
// R2: after release, wait about 38 self-clock cycles, then sample the reset pin
// R3: internal resets expect the post-release sample to read high
// R4: record the cause of each reset in the reset cause status register
// R5: an outside party may force reset by pulling the reset pin low
// R6: during reset the debug mode pin is only a mode-select input
// R7: after reset the debug mode pin becomes the single-wire debug pin
// R8: mode pin high at reset release selects normal operating mode
// R9: mode pin held low across reset release selects active background mode
// R10: as a port bit, the debug mode pin is output only
// R11: each debug link bit lasts 16 debug clock cycles
// R12: the debug clock may run as fast as the bus clock
// R13: releasing the debug line high starts with a short driven-high speedup pulse
// R14: fixed-frequency enable when main clock exceeds four times external reference
// R15: fixed-frequency enable low means the bus clock is the fixed clock
// R16: control bits pick main clock from crystal, external clock or oscillator
// R17: startup runs from the internal self-clock of about 8 MHz
// R18: the self-clock may be chosen as stop recovery clock
// R19: tools may choose the local self-clock as the debug clock
// R20: the external reference may clock the real-time interrupt
// R21: a range bit picks one of two crystal frequency ranges
// R22: with an external oscillator, the crystal output pin becomes a port bit
// R23: internal reset holds until the sample ends; mode latched at release

package rmcs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ      = 125_000_000;
  localparam longint SELF_HZ     = 8_000_000;
  localparam longint DRIVE_SELF  = 34;
  localparam longint WAIT_SELF   = 38;
  localparam longint DRIVE_CYC_L = (DRIVE_SELF * CLK_HZ + SELF_HZ - 1) / SELF_HZ;
  localparam longint WAIT_CYC_L  = (WAIT_SELF * CLK_HZ + SELF_HZ - 1) / SELF_HZ;
  localparam int     CNT_W       = 10;
  localparam logic [CNT_W-1:0] DRIVE_CYC = CNT_W'(DRIVE_CYC_L);
  localparam logic [CNT_W-1:0] WAIT_CYC  = CNT_W'(WAIT_CYC_L);
  localparam logic [3:0] LOCAL_DIV  = 4'(CLK_HZ / SELF_HZ);
  localparam logic [3:0] BIT_TICKS  = 4'hF;  // last tick index, 16 ticks a bit
  localparam logic [3:0] LOW_ONE    = 4'h4;
  localparam logic [3:0] LOW_ZERO   = 4'hD;
  localparam logic [2:0] FREF_RATIO_SH = 3'h2;  // times four as a shift

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET_CAUSE = 8'h00;
  localparam logic [7:0] REG_CLOCKGEN_C1 = 8'h01;
  localparam logic [7:0] REG_DBG_CTRL    = 8'h02;
  localparam logic [7:0] REG_DEBUG_TX    = 8'h03;
  localparam logic [7:0] REG_SYS_STATUS  = 8'h04;
  localparam logic [7:0] C1_RESET   = 8'h00;
  localparam logic [7:0] DBG_RESET  = 8'h00;
  localparam logic [3:0] CAUSE_POR  = 4'h1;
  localparam logic [3:0] CAUSE_PIN  = 4'h2;
  localparam logic [3:0] CAUSE_COP  = 4'h4;
  localparam logic [3:0] CAUSE_LVD  = 4'h8;
  localparam logic [1:0] SRC_CRYSTAL = 2'h0;
  localparam logic [1:0] SRC_EXTCLK = 2'h1;
  localparam logic [1:0] SRC_DCO    = 2'h2;
  localparam int C1_RANGE  = 2;
  localparam int C1_EXTOSC = 3;
  localparam int C1_STOPSC = 4;
  localparam int C1_RTIREF = 5;
  localparam int C1_XDATA  = 6;
  localparam int DBG_PORT  = 0;
  localparam int DBG_PDATA = 1;
  localparam int DBG_LOCAL = 2;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRIVE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_HOLD  = 2'b11
  } rmcs_state_t;

endpackage : rmcs_pkg

// ---- rmcs_pod.sv ----
// far-side model: external reset source and debug pod on the two shared pins
// assumes both pins carry pull-ups and the testbench steers the pod's intent
`timescale 1ns/1ns

module rmcs_pod (
  input  wire logic pull_reset,
  input  wire logic hold_mode_low,
  input  wire logic reset_pin_oe,
  input  wire logic reset_pin_out,
  input  wire logic debug_mode_pin_oe,
  input  wire logic debug_mode_pin_out,
  output logic      reset_pin_level,
  output logic      debug_pin_level
);
  // ------------------------------------------------------------
  // wire resolution
  // ------------------------------------------------------------
  // reset line: open drain, pull-up wins unless someone pulls low
  assign reset_pin_level = !((reset_pin_oe && !reset_pin_out) || pull_reset);
  // mode line: the device drive wins while enabled, else the pod holds low or the pull-up reads high
  assign debug_pin_level = debug_mode_pin_oe ? debug_mode_pin_out
                                             : !hold_mode_low;
endmodule : rmcs_pod

// ---- reset_mode_clock_select_tb_top.sv ----
// self-checking bench for the reset, mode select and clock select block
// assumes the pod model resolves both shared pins from every party's enable
`timescale 1ns/1ns

module reset_mode_clock_select_tb_top import rmcs_pkg::*;;
  logic        clock, reset_n, reg_write, reg_read, lvd_reset_req, cop_reset_req;
  logic        pull_reset, hold_mode_low, reset_pin_level, debug_pin_level;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [15:0] main_freq_khz, ext_ref_freq_khz;
  logic        reset_pin_out, reset_pin_oe, debug_mode_pin_out, debug_mode_pin_oe;
  logic        sys_reset_n, active_bkgd_mode, fixed_freq_enable, osc_range;
  logic        stop_self_clock_sel, rti_ext_ref_sel, debug_clk_local;
  logic        crystal_out_pin_out, crystal_out_pin_oe;
  logic [1:0]  main_clock_out_sel;
  int          err_count, checks;

  rmcs_top i_dut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .lvd_reset_req(lvd_reset_req), .cop_reset_req(cop_reset_req),
    .reset_pin_in(reset_pin_level), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .debug_mode_pin_in(debug_pin_level),
    .debug_mode_pin_out(debug_mode_pin_out), .debug_mode_pin_oe(debug_mode_pin_oe),
    .main_freq_khz(main_freq_khz), .ext_ref_freq_khz(ext_ref_freq_khz),
    .sys_reset_n(sys_reset_n), .active_bkgd_mode(active_bkgd_mode),
    .fixed_freq_enable(fixed_freq_enable), .main_clock_out_sel(main_clock_out_sel),
    .osc_range(osc_range), .stop_self_clock_sel(stop_self_clock_sel),
    .rti_ext_ref_sel(rti_ext_ref_sel), .debug_clk_local(debug_clk_local),
    .crystal_out_pin_out(crystal_out_pin_out), .crystal_out_pin_oe(crystal_out_pin_oe)
  );

  rmcs_pod i_pod (
    .pull_reset(pull_reset), .hold_mode_low(hold_mode_low),
    .reset_pin_oe(reset_pin_oe), .reset_pin_out(reset_pin_out),
    .debug_mode_pin_oe(debug_mode_pin_oe), .debug_mode_pin_out(debug_mode_pin_out),
    .reset_pin_level(reset_pin_level), .debug_pin_level(debug_pin_level)
  );

  // 8 ns period stands in for the self-clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // a bounded wait ran out: count it and close the run
  task automatic give_up;
    err_count++;
    results;
  endtask : give_up

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // one whole reset sequence: drive length, wait length, cause, mode
  task automatic run_seq(input logic [3:0] cause, input logic bkgd);
    int n;
    int w;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (reset_pin_oe !== 1'b1 && n < 40);
    if (reset_pin_oe !== 1'b1) give_up;
    pull_reset <= 1'b0;
    n = 0;
    while (reset_pin_oe === 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 2000) give_up;
    check(16'(n), 16'(DRIVE_CYC));
    check(16'(reset_pin_out), 16'h0000);
    check(16'(sys_reset_n), 16'h0000);
    check(16'(debug_mode_pin_oe), 16'h0000);
    w = 0;
    while (sys_reset_n !== 1'b1 && w < 2000) begin
      @(negedge clock);
      w++;
    end
    if (w >= 2000) give_up;
    check(16'(w >= int'(WAIT_CYC) - 1 && w <= int'(WAIT_CYC) + 8), 16'h0001);
    check(16'(active_bkgd_mode), 16'(bkgd));
    rd(REG_RESET_CAUSE, d);
    check(16'(d), 16'(cause));
  endtask : run_seq

  // every source code, the refused code, then the single-bit controls
  task automatic clock_select;
    for (int i = 0; i < 3; i++) begin
      wr(REG_CLOCKGEN_C1, 8'(i));
      settle(2);
      check(16'(main_clock_out_sel), 16'(i));
    end
    wr(REG_CLOCKGEN_C1, 8'h03);
    settle(2);
    check(16'(main_clock_out_sel), 16'(SRC_DCO));
    wr(REG_CLOCKGEN_C1, 8'h7C);
    settle(2);
    check(16'({osc_range, crystal_out_pin_oe, crystal_out_pin_out}), 16'h0007);
    check(16'({stop_self_clock_sel, rti_ext_ref_sel}), 16'h0003);
    wr(REG_CLOCKGEN_C1, 8'h00);
  endtask : clock_select

  // exactly four times the reference is not above it: boundary both sides
  task automatic fixed_freq;
    @(posedge clock);
    main_freq_khz    <= 16'h0FA1;
    ext_ref_freq_khz <= 16'h03E8;
    settle(4);
    check(16'(fixed_freq_enable), 16'h0001);
    rd(REG_SYS_STATUS, d);
    check(16'(d[0]), 16'h0001);
    @(posedge clock);
    main_freq_khz <= 16'h0FA0;
    settle(4);
    check(16'(fixed_freq_enable), 16'h0000);
  endtask : fixed_freq

  // port use drives the pin steadily; a debug bit is refused meanwhile
  task automatic port_mode;
    wr(REG_DBG_CTRL, 8'h03);
    settle(2);
    check(16'({debug_mode_pin_oe, debug_mode_pin_out}), 16'h0003);
    wr(REG_DBG_CTRL, 8'h01);
    settle(2);
    check(16'({debug_mode_pin_oe, debug_mode_pin_out}), 16'h0002);
    wr(REG_DEBUG_TX, 8'h01);
    rd(REG_DEBUG_TX, d);
    check(16'(d[0]), 16'h0000);
    wr(REG_DBG_CTRL, 8'h00);
  endtask : port_mode

  // one debug bit: low time, speedup pulse and busy clear by the end of a 17-tick window
  task automatic tx_bit(input logic b, input int tick);
    int lo;
    int hi;
    lo = 0;
    hi = 0;
    wr(REG_DEBUG_TX, {7'h00, b});
    for (int i = 0; i < 17 * tick + 4; i++) begin
      @(negedge clock);
      if (debug_mode_pin_oe === 1'b1 && debug_mode_pin_out === 1'b0) lo++;
      if (debug_mode_pin_oe === 1'b1 && debug_mode_pin_out === 1'b1) hi++;
    end
    check(16'(lo), 16'((b ? 4 : 13) * tick));
    check(16'(hi), 16'(tick));
    rd(REG_DEBUG_TX, d);
    check(16'(d[0]), 16'h0000);
  endtask : tx_bit

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    lvd_reset_req = 1'b0;
    cop_reset_req = 1'b0;
    pull_reset = 1'b0;
    hold_mode_low = 1'b0;
    main_freq_khz = 16'h0000;
    ext_ref_freq_khz = 16'h0000;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    run_seq(CAUSE_POR, 1'b0);
    clock_select();
    fixed_freq();
    port_mode();
    tx_bit(1'b1, 1);
    tx_bit(1'b0, 1);
    wr(REG_DBG_CTRL, 8'h04);
    settle(2);
    check(16'(debug_clk_local), 16'h0001);
    tx_bit(1'b1, int'(LOCAL_DIV));
    wr(REG_DBG_CTRL, 8'h00);
    // pod holds the mode line low across a watchdog reset
    hold_mode_low <= 1'b1;
    @(posedge clock);
    cop_reset_req <= 1'b1;
    @(posedge clock);
    cop_reset_req <= 1'b0;
    run_seq(CAUSE_COP, 1'b1);
    hold_mode_low <= 1'b0;
    settle(8);
    check(16'(active_bkgd_mode), 16'h0001);
    @(posedge clock);
    lvd_reset_req <= 1'b1;
    @(posedge clock);
    lvd_reset_req <= 1'b0;
    run_seq(CAUSE_LVD, 1'b0);
    pull_reset <= 1'b1;
    run_seq(CAUSE_PIN, 1'b0);
    rd(8'h05, d);
    check(16'(d), 16'h0000);
    results();
  end
endmodule : reset_mode_clock_select_tb_top
